// file: verilog/ext_irq_pkg.sv
// constants, offsets and carrier types of the external pin interrupt unit
// assumes a 32-bit apb slave with word-aligned registers
package ext_irq_pkg;
  localparam int NUM_EXT = 3;
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_W = 8;
  localparam int NUM_PC = NUM_GROUPS * GROUP_W;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_EDGE_SENSE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EXT_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EXT_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PC_GROUP_EN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PC_GROUP_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_GROUP0_PIN_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_GROUP1_PIN_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_GROUP2_PIN_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_GROUP3_PIN_MASK = 8'h20;

  localparam logic [7:0] RST_EDGE_SENSE = 8'h00;
  localparam logic [7:0] RST_EXT_MASK = 8'h00;
  localparam logic [7:0] RST_EXT_FLAGS = 8'h00;
  localparam logic [7:0] RST_PC_GROUP_EN = 8'h00;
  localparam logic [7:0] RST_PC_GROUP_FLAGS = 8'h00;
  localparam logic [7:0] RST_PIN_MASK = 8'h00;

  localparam int SENSE_FIELD_W = 2;
  localparam int SENSE_USED_MSB = 5;
  localparam int SENSE_RSVD_MSB = 7;
  localparam int SENSE_RSVD_LSB = 6;

  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY_EDGE = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING = 2'h3
  } sense_mode_t;

  typedef struct packed {
    logic [NUM_GROUPS-1:0] pc;
    logic [NUM_EXT-1:0] ext;
  } irq_lines_t;
endpackage

// file: verilog/pin_sync.sv
// two-stage synchroniser plus one history stage for a group of pins
// assumes pins are asynchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_sync_q,
  output logic [WIDTH-1:0] pin_prev_q
);
  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end else begin
      stage1_reg <= pin_raw;
      pin_sync_q <= stage1_reg;
      pin_prev_q <= pin_sync_q;
    end
  end
endmodule
`default_nettype wire

// file: verilog/external_pin_interrupts.sv
// external request pins and pin-change groups turned into interrupt lines
// assumes apb master on pclk, cpu dispatch pulses vector_taken per line
//
// Summary of operation
// - four groups of eight change inputs
// - pins detected even when driven as outputs
// - pin changes seen without clock for wake
// - sense code: low, any, falling, rising
// - low level keeps requesting while held
// - level and edges wake without clock
// - level gone before start-up: no interrupt
// - reserved sense bits read zero
// - pin mask and global bit gate request
// - flag set on event, cleared by vector/one
// - flag held clear in level mode
// - sleep with request off gates input buffer
// - group enable bits drive group vector
// - pin mask selects contributing pins
// - group flag set, cleared by vector/one
// - pin masks enable per pin, reset zero
`timescale 1ns/10ps
`default_nettype none
module external_pin_interrupts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ext_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ext_irq_pkg::NUM_EXT-1:0] ext_request_pins,
  input wire logic [ext_irq_pkg::NUM_PC-1:0] pin_change_inputs,
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire ext_irq_pkg::irq_lines_t vector_taken,
  output ext_irq_pkg::irq_lines_t irq_request,
  output logic wake_request
);
  localparam int NE = ext_irq_pkg::NUM_EXT;
  localparam int NG = ext_irq_pkg::NUM_GROUPS;
  localparam int GW = ext_irq_pkg::GROUP_W;
  localparam int NP = ext_irq_pkg::NUM_PC;

  logic [7:0] edge_sense_control_reg;
  logic [NE-1:0] ext_request_enable_mask_reg;
  logic [NE-1:0] ext_request_flags_reg;
  logic [NE-1:0] ext_request_flags_next;
  logic [NG-1:0] pin_change_group_enable_reg;
  logic [NG-1:0] pin_change_group_flags_reg;
  logic [NG-1:0] pin_change_group_flags_next;
  logic [NP-1:0] group_pin_mask_reg;
  logic [NP-1:0] group_pin_mask_next;
  logic [31:0] prdata_next;
  logic pslverr_next;

  logic [NE-1:0] ext_sync;
  logic [NE-1:0] ext_seen_reg;
  logic [NE-1:0] ext_seen;
  logic [NE-1:0] ext_seen_prev;
  logic [NE-1:0] ext_level_mode;
  logic [NE-1:0] ext_set;
  logic [NE-1:0] ext_level_req;
  logic [NP-1:0] pc_sync;
  logic [NP-1:0] pc_prev;
  logic [NP-1:0] pc_changed;
  logic [NG-1:0] pc_set;
  logic [NE-1:0] ext_async_hit;
  logic [NE-1:0] ext_irq;
  logic [NG-1:0] pc_irq;

  logic setup_phase;
  logic wr_access;
  logic [7:0] wbyte;
  logic addr_hit;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;

  always_comb begin
    addr_hit = 1'b1;
    prdata_next = 32'h0000_0000;
    case (paddr)
      ext_irq_pkg::OFF_EDGE_SENSE: begin
        prdata_next[ext_irq_pkg::SENSE_USED_MSB:0] = edge_sense_control_reg[ext_irq_pkg::SENSE_USED_MSB:0];
      end
      ext_irq_pkg::OFF_EXT_MASK: begin
        prdata_next[NE-1:0] = ext_request_enable_mask_reg;
      end
      ext_irq_pkg::OFF_EXT_FLAGS: begin
        prdata_next[NE-1:0] = ext_request_flags_reg;
      end
      ext_irq_pkg::OFF_PC_GROUP_EN: begin
        prdata_next[NG-1:0] = pin_change_group_enable_reg;
      end
      ext_irq_pkg::OFF_PC_GROUP_FLAGS: begin
        prdata_next[NG-1:0] = pin_change_group_flags_reg;
      end
      ext_irq_pkg::OFF_GROUP0_PIN_MASK: begin
        prdata_next[GW-1:0] = group_pin_mask_reg[0*GW +: GW];
      end
      ext_irq_pkg::OFF_GROUP1_PIN_MASK: begin
        prdata_next[GW-1:0] = group_pin_mask_reg[1*GW +: GW];
      end
      ext_irq_pkg::OFF_GROUP2_PIN_MASK: begin
        prdata_next[GW-1:0] = group_pin_mask_reg[2*GW +: GW];
      end
      ext_irq_pkg::OFF_GROUP3_PIN_MASK: begin
        prdata_next[GW-1:0] = group_pin_mask_reg[3*GW +: GW];
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    pslverr_next = !addr_hit;
  end

  // read data and error captured in setup, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : prdata_next;
      pslverr <= pslverr_next;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sense_control_reg <= ext_irq_pkg::RST_EDGE_SENSE;
    end else if (wr_access && paddr == ext_irq_pkg::OFF_EDGE_SENSE) begin
      edge_sense_control_reg <= {2'h0, wbyte[ext_irq_pkg::SENSE_USED_MSB:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_request_enable_mask_reg <= ext_irq_pkg::RST_EXT_MASK[NE-1:0];
    end else if (wr_access && paddr == ext_irq_pkg::OFF_EXT_MASK) begin
      ext_request_enable_mask_reg <= wbyte[NE-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_group_enable_reg <= ext_irq_pkg::RST_PC_GROUP_EN[NG-1:0];
    end else if (wr_access && paddr == ext_irq_pkg::OFF_PC_GROUP_EN) begin
      pin_change_group_enable_reg <= wbyte[NG-1:0];
    end
  end

  always_comb begin
    group_pin_mask_next = group_pin_mask_reg;
    if (wr_access) begin
      case (paddr)
        ext_irq_pkg::OFF_GROUP0_PIN_MASK: group_pin_mask_next[0*GW +: GW] = wbyte;
        ext_irq_pkg::OFF_GROUP1_PIN_MASK: group_pin_mask_next[1*GW +: GW] = wbyte;
        ext_irq_pkg::OFF_GROUP2_PIN_MASK: group_pin_mask_next[2*GW +: GW] = wbyte;
        ext_irq_pkg::OFF_GROUP3_PIN_MASK: group_pin_mask_next[3*GW +: GW] = wbyte;
        default: group_pin_mask_next = group_pin_mask_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_pin_mask_reg <= {NG{ext_irq_pkg::RST_PIN_MASK}};
    end else begin
      group_pin_mask_reg <= group_pin_mask_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; no direction gating, so driven outputs still count
  pin_sync #(.WIDTH(NE)) ext_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(ext_request_pins),
    .pin_sync_q(ext_sync),
    .pin_prev_q()
  );

  pin_sync #(.WIDTH(NP)) pc_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(pin_change_inputs),
    .pin_sync_q(pc_sync),
    .pin_prev_q(pc_prev)
  );

  //////////////////////////////////////////////////////////////////////////////
  // external request sensing
  always_comb begin
    for (int i = 0; i < NE; i++) begin
      // disabled input buffer during sleep reads as low
      ext_seen[i] = (sleep_active && !ext_request_enable_mask_reg[i]) ? 1'b0 : ext_sync[i];
      ext_seen_prev[i] = ext_seen_reg[i];
      ext_level_mode[i] = edge_sense_control_reg[2*i +: 2] == ext_irq_pkg::SENSE_LOW_LEVEL;
      case (edge_sense_control_reg[2*i +: 2])
        ext_irq_pkg::SENSE_ANY_EDGE: ext_set[i] = ext_seen[i] ^ ext_seen_prev[i];
        ext_irq_pkg::SENSE_FALLING: ext_set[i] = !ext_seen[i] && ext_seen_prev[i];
        ext_irq_pkg::SENSE_RISING: ext_set[i] = ext_seen[i] && !ext_seen_prev[i];
        default: ext_set[i] = 1'b0;
      endcase
      // level request follows the present level only
      ext_level_req[i] = ext_level_mode[i] && !ext_seen[i];
    end
  end

  // history of the gated level, so sleep gating gives one edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_seen_reg <= '0;
    end else begin
      ext_seen_reg <= ext_seen;
    end
  end

  always_comb begin
    ext_request_flags_next = ext_request_flags_reg;
    if (wr_access && paddr == ext_irq_pkg::OFF_EXT_FLAGS) begin
      ext_request_flags_next = ext_request_flags_next & ~wbyte[NE-1:0];
    end
    ext_request_flags_next = ext_request_flags_next & ~vector_taken.ext;
    ext_request_flags_next = ext_request_flags_next | ext_set;
    ext_request_flags_next = ext_request_flags_next & ~ext_level_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_request_flags_reg <= ext_irq_pkg::RST_EXT_FLAGS[NE-1:0];
    end else begin
      ext_request_flags_reg <= ext_request_flags_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin-change groups
  assign pc_changed = (pc_sync ^ pc_prev) & group_pin_mask_reg;

  always_comb begin
    for (int g = 0; g < NG; g++) begin
      pc_set[g] = |pc_changed[g*GW +: GW];
    end
  end

  always_comb begin
    pin_change_group_flags_next = pin_change_group_flags_reg;
    if (wr_access && paddr == ext_irq_pkg::OFF_PC_GROUP_FLAGS) begin
      pin_change_group_flags_next = pin_change_group_flags_next & ~wbyte[NG-1:0];
    end
    pin_change_group_flags_next = pin_change_group_flags_next & ~vector_taken.pc;
    pin_change_group_flags_next = pin_change_group_flags_next | pc_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_group_flags_reg <= ext_irq_pkg::RST_PC_GROUP_FLAGS[NG-1:0];
    end else begin
      pin_change_group_flags_reg <= pin_change_group_flags_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // requests to the cpu and clockless wake path
  assign ext_irq = ((ext_request_flags_reg | ext_level_req) & ext_request_enable_mask_reg)
                   & {NE{global_irq_enable}};
  assign pc_irq = pin_change_group_flags_reg & pin_change_group_enable_reg
                  & {NG{global_irq_enable}};
  assign irq_request = {pc_irq, ext_irq};

  // combinational compare against the last settled level needs no clock edge
  always_comb begin
    for (int i = 0; i < NE; i++) begin
      case (edge_sense_control_reg[2*i +: 2])
        ext_irq_pkg::SENSE_LOW_LEVEL: ext_async_hit[i] = !ext_request_pins[i];
        ext_irq_pkg::SENSE_ANY_EDGE: ext_async_hit[i] = ext_request_pins[i] ^ ext_sync[i];
        ext_irq_pkg::SENSE_FALLING: ext_async_hit[i] = !ext_request_pins[i] && ext_sync[i];
        default: ext_async_hit[i] = ext_request_pins[i] && !ext_sync[i];
      endcase
    end
  end

  assign wake_request = |(ext_async_hit & ext_request_enable_mask_reg)
                        || |(((pin_change_inputs ^ pc_sync) & group_pin_mask_reg) != '0)
                        || |irq_request;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  level_flag_clear_a: assert property ((ext_request_flags_reg & $past(ext_level_mode)) == '0)
    else $error("flag set while pin in level mode");

  level_irq_hold_a: assert property ((ext_level_mode[0] && !ext_seen[0] && ext_request_enable_mask_reg[0]
    && global_irq_enable) |-> irq_request.ext[0])
    else $error("level request not held");

  ext_gate_irq_a: assert property ((irq_request.ext != '0) |-> global_irq_enable
    && ((irq_request.ext & ~ext_request_enable_mask_reg) == '0))
    else $error("external request ungated");

  pc_gate_irq_a: assert property ((irq_request.pc != '0) |-> global_irq_enable
    && ((irq_request.pc & ~pin_change_group_enable_reg) == '0))
    else $error("group request ungated");

  set_beats_clear_a: assert property ((pc_set != '0) |=> ((pin_change_group_flags_reg & $past(pc_set))
    == $past(pc_set)))
    else $error("set lost to clear");

  sync_latency_a: assert property ($past(presetn, 2) |-> pc_sync == $past(pin_change_inputs, 2))
    else $error("sync depth wrong");

  sense_rsvd_zero_a: assert property ((psel && penable && !pwrite && paddr == ext_irq_pkg::OFF_EDGE_SENSE)
    |-> prdata[7:6] == 2'h0)
    else $error("reserved sense bits nonzero");

  w1c_group_a: assert property ((wr_access && paddr == ext_irq_pkg::OFF_PC_GROUP_FLAGS && wbyte[0]
    && !pc_set[0]) |=> !pin_change_group_flags_reg[0])
    else $error("group flag not cleared by one");

  vector_clear_a: assert property ((vector_taken.ext[1] && !ext_set[1]) |=> !ext_request_flags_reg[1])
    else $error("vector entry did not clear flag");

  masked_pin_quiet_a: assert property ((group_pin_mask_reg[GW-1:0] == '0) |-> !pc_set[0])
    else $error("masked pins raised group");

  falling_sets_a: assert property ((edge_sense_control_reg[1:0] == ext_irq_pkg::SENSE_FALLING
    && ext_seen_prev[0] && !ext_seen[0]) |=> ext_request_flags_reg[0])
    else $error("falling edge missed");

  ext_w1c_clear_a: assert property ((wr_access && paddr == ext_irq_pkg::OFF_EXT_FLAGS && wbyte[0]
    && !ext_set[0]) |=> !ext_request_flags_reg[0])
    else $error("external flag not cleared by one");

  pc_vector_clear_a: assert property ((vector_taken.pc[0] && !pc_set[0]) |=> !pin_change_group_flags_reg[0])
    else $error("group vector entry did not clear flag");
endmodule
`default_nettype wire

// file: bench/cpu_dispatch_model.sv
// cpu dispatch partner: answers interrupt lines with vector pulses
// assumes same pclk and presetn as the unit under test
`timescale 1ns/10ps
`default_nettype none
module cpu_dispatch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire ext_irq_pkg::irq_lines_t irq_request,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  output ext_irq_pkg::irq_lines_t vector_taken
);
  logic [6:0] req;
  logic [3:0] cnt;
  assign req = irq_request;
  ////////////////////////////////////////////////////////////////
  // one pulse on the lowest pending line after ack_delay cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_taken <= '0;
      cnt <= 4'h0;
    end else begin
      vector_taken <= '0;
      if (ack_en && req !== 7'h00 && vector_taken == '0) begin
        if (cnt >= ack_delay) begin
          vector_taken <= ext_irq_pkg::irq_lines_t'(req & (~req + 7'h01));
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/external_pin_interrupts_tb.sv
// self-checking bench: apb master, pin driver, register model
// assumes cpu_dispatch_model answers vector pulses
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module external_pin_interrupts_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0] pstrb = 4'hf, ack_delay = 4'h0;
  logic pready, pslverr, wake_request, global_irq_enable = 1'b0, sleep_active = 1'b0, ack_en = 1'b0;
  logic [2:0] ext_request_pins = 3'h7;
  logic [31:0] pin_change_inputs = 32'h0000_0000;
  ext_irq_pkg::irq_lines_t vector_taken, irq_request;
  logic [7:0] mdl [0:8];
  int failures = 0, cmp_count = 0, g, b, m, i;
  always #5 pclk = ~pclk;
  external_pin_interrupts external_pin_interrupts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_request_pins(ext_request_pins),
    .pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable),
    .sleep_active(sleep_active), .vector_taken(vector_taken), .irq_request(irq_request),
    .wake_request(wake_request));
  cpu_dispatch_model cpu_dispatch_model_i (.pclk(pclk), .presetn(presetn), .irq_request(irq_request),
    .ack_en(ack_en), .ack_delay(ack_delay), .vector_taken(vector_taken));
  ////////////////////////////////////////////////////////////////
  task end_sim;
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function logic [7:0] wmask(input int k);
    case (k)
      0: return 8'h3f;
      1, 2: return 8'h07;
      3, 4: return 8'h0f;
      default: return 8'hff;
    endcase
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    int k;
    k = a / 4;
    apb(1'b1, a, d, r, e);
    `CHK("wr_err", 1'(k > 8), e)
    if (k == 2 || k == 4) mdl[k] = mdl[k] & ~d[7:0];
    else if (k <= 8) mdl[k] = d[7:0] & wmask(k);
  endtask
  task rd_chk(input logic [7:0] a);
    logic [31:0] r;
    logic e;
    int k;
    k = a / 4;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK("prdata", (k > 8) ? 32'h0000_0000 : {24'h00_0000, mdl[k]}, r)
    `CHK("rd_err", 1'(k > 8), e)
  endtask
  task ext_drive(input int n, input logic v);
    logic o;
    int s;
    o = ext_request_pins[n];
    s = (mdl[0] >> (2 * n)) & 3;
    @(posedge pclk);
    ext_request_pins[n] <= v;
    tick(6);
    if ((s == 1 && o != v) || (s == 2 && o && !v) || (s == 3 && !o && v)) mdl[2][n] = 1'b1;
  endtask
  task pc_toggle(input int p);
    @(posedge pclk);
    pin_change_inputs[p] <= ~pin_change_inputs[p];
    tick(6);
    if (mdl[5 + p / 8][p % 8]) mdl[4][p / 8] = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h69b7));
    pin_change_inputs <= $urandom;
    for (i = 0; i < 9; i++) mdl[i] = 8'h00;
    tick(8);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++) rd_chk(8'(4 * i));
    wr(8'h24, $urandom);
    for (i = 0; i < 9; i++) begin
      wr(8'(4 * i), $urandom);
      rd_chk(8'(4 * i));
    end
    for (i = 0; i < 5; i++) wr(8'(4 * i), 32'h0000_00ff);
    sleep_active <= 1'b1;
    for (g = 0; g < 4; g++) begin
      b = $urandom_range(7);
      m = 1 << b;
      wr(8'(8'h14 + 4 * g), m);
      wr(8'h0c, 1 << g);
      pc_toggle(8 * g + (b + 1) % 8);
      rd_chk(8'h10);
      pc_toggle(8 * g + b);
      rd_chk(8'h10);
      `CHK("pc_irq_off", 1'b0, irq_request.pc[g])
      global_irq_enable <= 1'b1;
      tick(2);
      `CHK("pc_irq_on", 1'b1, irq_request.pc[g])
      wr(8'h10, 1 << g);
      rd_chk(8'h10);
      ack_delay <= 4'($urandom_range(9));
      ack_en <= 1'b1;
      pc_toggle(8 * g + b);
      tick(20);
      mdl[4][g] = 1'b0;
      rd_chk(8'h10);
      ack_en <= 1'b0;
      global_irq_enable <= 1'b0;
    end
    sleep_active <= 1'b0;
    for (m = 1; m < 4; m++) begin
      wr(8'h00, m * 8'h15);
      wr(8'h08, 32'h0000_0007);
      for (i = 0; i < 3; i++) begin
        ext_drive(i, 1'b0);
        rd_chk(8'h08);
        ext_drive(i, 1'b1);
        rd_chk(8'h08);
      end
    end
    wr(8'h04, 32'h0000_0002);
    global_irq_enable <= 1'b1;
    ack_en <= 1'b1;
    ext_drive(1, 1'b0);
    ext_drive(1, 1'b1);
    tick(20);
    mdl[2][1] = 1'b0;
    rd_chk(8'h08);
    ack_en <= 1'b0;
    wr(8'h00, 32'h0000_0000);
    mdl[2] = 8'h00;
    rd_chk(8'h08);
    wr(8'h04, 32'h0000_0001);
    ext_drive(0, 1'b0);
    `CHK("lvl_irq", 1'b1, irq_request.ext[0])
    `CHK("wake", 1'b1, wake_request)
    rd_chk(8'h08);
    tick(30);
    `CHK("lvl_hold", 1'b1, irq_request.ext[0])
    global_irq_enable <= 1'b0;
    tick(2);
    `CHK("lvl_gbl", 1'b0, irq_request.ext[0])
    ext_drive(0, 1'b1);
    `CHK("lvl_off", 1'b0, irq_request.ext[0])
    `CHK("wake_off", 1'b0, wake_request)
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0002);
    wr(8'h08, 32'h0000_0007);
    sleep_active <= 1'b1;
    tick(6);
    mdl[2][0] = 1'b1;
    rd_chk(8'h08);
    sleep_active <= 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
